//--- irqc_pkg.sv
// Purpose: constants shared by the interrupt flag and vector controller
// Assumes: 32-bit apb data, one aligned word per register
// Notes: byte offsets, bit positions, reset values and counts live here
package irqc_pkg;

    // ==================================================================
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00; // irq_control_reg
    localparam logic [7:0] OFF_PFLAG = 8'h04; // periph_flag_reg
    localparam logic [7:0] OFF_PEN = 8'h08; // periph_enable_reg
    localparam logic [7:0] OFF_OPTION = 8'h0C; // option bits, edge select
    localparam logic [7:0] OFF_TIMER = 8'h10; // timer0_count
    localparam logic [7:0] OFF_STATUS = 8'h14; // core-side state, read only

    // ==================================================================
    // irq_control_reg bit positions
    localparam int unsigned B_GIE = 7; // global_irq_enable
    localparam int unsigned B_PERIPH_GROUP_ENABLE = 6; // periph_group_enable
    localparam int unsigned B_T0IE = 5; // timer0_wrap_enable
    localparam int unsigned B_EXTIE = 4; // ext_pin_enable
    localparam int unsigned B_PCIE = 3; // port_change_enable
    localparam int unsigned B_T0IF = 2; // timer0_wrap_flag
    localparam int unsigned B_EXTIF = 1; // ext_pin_flag
    localparam int unsigned B_PCIF = 0; // port_change_flag
    localparam int unsigned B_EDGE = 6; // ext_edge_select in option reg

    // ==================================================================
    // reset values
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_PFLAG = 8'h00;
    localparam logic [7:0] RST_PEN = 8'h00;
    localparam logic [7:0] RST_OPTION = 8'hFF;
    localparam logic [7:0] RST_TIMER = 8'h00;
    localparam logic [7:0] FLAG_MASK = 8'h07; // software write-one-to-clear bits

    // ==================================================================
    // vectoring
    localparam logic [12:0] VECTOR_ADDR = 13'h0004;
    localparam int unsigned MAX_SOURCES = 17;
    localparam int unsigned CORE_SOURCES = 3;
    localparam logic [1:0] LAT_BOUNDS = 2'h2; // boundaries waited before vector
    localparam logic [2:0] SHARED_TOP = 3'h7; // upper 16 bytes of a bank

endpackage : irqc_pkg

//--- irqc_evt_detect.sv
// Purpose: edge detect on the external pin and change detect on port b
// Assumes: pins are synchronous to pclk
// Notes: first clock after reset only primes the history
`timescale 1ns/1ns
module irqc_evt_detect
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // pins and selection
    input wire logic ext_irq_pin,
    input wire logic [3:0] port_b_pins,
    input wire logic ext_edge_select,
    // event pulses
    output logic ext_evt,
    output logic port_evt
);
    import irqc_pkg::*;

    logic ext_prev_r; // last sampled pin level
    logic [3:0] port_prev_r; // last sampled upper nibble
    logic primed_r; // history valid
    wire rise_w = ext_irq_pin & ~ext_prev_r;
    wire fall_w = ~ext_irq_pin & ext_prev_r;

    // ==================================================================
    // edge selection and change compare
    assign ext_evt = primed_r & (ext_edge_select ? rise_w : fall_w);
    assign port_evt = primed_r & (|(port_b_pins ^ port_prev_r));

    // history registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ext_prev_r <= 1'b0;
            port_prev_r <= 4'h0;
            primed_r <= 1'b0;
        end
        else
        begin
            ext_prev_r <= ext_irq_pin;
            port_prev_r <= port_b_pins;
            primed_r <= 1'b1;
        end
    end

endmodule : irqc_evt_detect

//--- irqc_ctx_ram.sv
// Purpose: shared 16-byte context store seen from every data bank
// Assumes: core data port with bank select and 7-bit address
// Notes: read data is registered, one cycle after the address
`timescale 1ns/1ns
module irqc_ctx_ram
#(
    parameter int unsigned DEPTH = 16
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // core data port
    input wire logic [1:0] bank,
    input wire logic [6:0] addr,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data_r,
    output logic hit_r
);
    import irqc_pkg::*;

    logic [7:0] mem [DEPTH]; // common storage, no bank bits in index
    wire hit_w = (addr[6:4] == SHARED_TOP);
    wire [3:0] idx_w = addr[3:0];
    wire unused_bank_w = ^bank; // bank deliberately ignored

    // ==================================================================
    // storage write, same cell for all banks
    always_ff @(posedge pclk)
    begin
        if (wr_en && hit_w)
        begin
            mem[idx_w] <= wr_data;
        end
    end

    // registered read
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_data_r <= 8'h00;
            hit_r <= 1'b0;
        end
        else
        begin
            rd_data_r <= hit_w ? mem[idx_w] : 8'h00;
            hit_r <= hit_w & ~(unused_bank_w & 1'b0);
        end
    end

endmodule : irqc_ctx_ram

//--- irqc_ctrl.sv
// Purpose: interrupt flag latching, masking and vectoring for the core
// Assumes: apb register access; instr_boundary pulses once per instruction
// Notes: flags are write-one-to-clear; a set in the same cycle wins
//
// Overview of operation
// - at most seventeen interrupt sources in total
// - flags set regardless of any enable
// - global enable permits or blocks all requests
// - enabled pending request vectors on the third instruction boundary
// - every reset clears the global enable
// - accept: clear global enable, push, load 0004h
// - return from interrupt sets global enable again
// - peripheral flags gated by enables and group enable
// - pin events serviced three or four instructions later
// - external pin edge chosen by edge select
// - external edge sets bit 1, enable bit 4
// - external pin wakes sleep; global enable decides vector
// - timer wrap FFh to 00h sets bit 2
// - port b upper nibble change sets bit 0
// - only the return address is saved
// - top 16 bytes of each bank are shared
// - wake-up cause visible in flag bits
`timescale 1ns/1ns
module irqc_ctrl
#(
    parameter int unsigned PERIPH_W = 8 // peripheral sources in periph_flag_reg
)
(
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt sources
    input wire logic ext_irq_pin,
    input wire logic [3:0] port_b_pins,
    input wire logic timer0_tick,
    input wire logic [PERIPH_W-1:0] periph_evt,
    // core handshake
    input wire logic instr_boundary,
    input wire logic return_from_interrupt,
    input wire logic sleep_enter,
    output logic vector_load,
    output logic [12:0] vector_addr,
    output logic ret_push,
    output logic wake,
    output logic irq,
    // shared context store
    input wire logic [1:0] ctx_bank,
    input wire logic [6:0] ctx_addr,
    input wire logic ctx_wr,
    input wire logic [7:0] ctx_wdata,
    output logic [7:0] ctx_rdata,
    output logic ctx_hit
);
    import irqc_pkg::*;

    // ==================================================================
    // types and state
    typedef enum logic [2:0] {
        ST_RUN = 3'b001, // executing, no request counted
        ST_PEND = 3'b010, // enabled request waiting for boundaries
        ST_SLEEP = 3'b100 // halted until an enabled flag rises
    } irqc_state_e;

    irqc_state_e state_r, state_nxt;
    logic [7:0] ctrl_r, ctrl_nxt; // irq_control_reg
    logic [PERIPH_W-1:0] pflag_r, pflag_nxt; // periph_flag_reg
    logic [PERIPH_W-1:0] pen_r; // periph_enable_reg
    logic [7:0] option_r; // option bits
    logic [7:0] timer_r, timer_nxt; // timer0_count
    logic [1:0] bound_cnt_r, bound_cnt_nxt; // boundaries seen while pending
    logic in_handler_r, in_handler_nxt; // between vector and return
    logic vector_load_r, ret_push_r, wake_r, irq_r;
    logic [31:0] prdata_r;
    logic pready_r, pslverr_r;

    // source count must fit the documented total
    localparam int unsigned NUM_SOURCES = CORE_SOURCES + PERIPH_W;
    if (NUM_SOURCES > MAX_SOURCES)
    begin : g_too_many
        // stops elaboration when the peripheral width breaks the source cap
        $error("irqc_ctrl: more interrupt sources than the cap allows");
    end

    // ==================================================================
    // bus decode
    wire setup_w = psel & ~penable;
    wire access_w = psel & penable & pready_r;
    wire wr_w = access_w & pwrite;
    wire sel_ctrl_w = (paddr == OFF_CTRL);
    wire sel_pflag_w = (paddr == OFF_PFLAG);
    wire sel_pen_w = (paddr == OFF_PEN);
    wire sel_opt_w = (paddr == OFF_OPTION);
    wire sel_tmr_w = (paddr == OFF_TIMER);
    wire sel_stat_w = (paddr == OFF_STATUS);
    wire mapped_w = sel_ctrl_w | sel_pflag_w | sel_pen_w | sel_opt_w | sel_tmr_w | sel_stat_w;
    wire wr_ctrl_w = wr_w & sel_ctrl_w;
    wire wr_pflag_w = wr_w & sel_pflag_w;
    wire wr_tmr_w = wr_w & sel_tmr_w;

    // pads a peripheral-width vector into a data word
    function automatic logic [31:0] widen(input logic [PERIPH_W-1:0] v);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[PERIPH_W-1:0] = v;
        return w;
    endfunction : widen

    // ==================================================================
    // event sources
    logic ext_evt_w, port_evt_w;
    irqc_evt_detect u_evt (
        .pclk(pclk),
        .presetn(presetn),
        .ext_irq_pin(ext_irq_pin),
        .port_b_pins(port_b_pins),
        .ext_edge_select(option_r[B_EDGE]),
        .ext_evt(ext_evt_w),
        .port_evt(port_evt_w)
    );

    // shared context store
    irqc_ctx_ram #(.DEPTH(16)) u_ctx (
        .pclk(pclk),
        .presetn(presetn),
        .bank(ctx_bank),
        .addr(ctx_addr),
        .wr_en(ctx_wr),
        .wr_data(ctx_wdata),
        .rd_data_r(ctx_rdata),
        .hit_r(ctx_hit)
    );

    // timer wrap when counting from all ones
    wire wrap_w = timer0_tick & (timer_r == 8'hFF) & ~wr_tmr_w;

    // ==================================================================
    // request masking
    wire ext_req_w = ctrl_r[B_EXTIF] & ctrl_r[B_EXTIE];
    wire tmr_req_w = ctrl_r[B_T0IF] & ctrl_r[B_T0IE];
    wire pc_req_w = ctrl_r[B_PCIF] & ctrl_r[B_PCIE];
    wire per_req_w = (|(pflag_r & pen_r)) & ctrl_r[B_PERIPH_GROUP_ENABLE];
    wire any_req_w = ext_req_w | tmr_req_w | pc_req_w | per_req_w;
    wire take_w = any_req_w & ctrl_r[B_GIE];
    wire fire_w = take_w & instr_boundary & (bound_cnt_r == LAT_BOUNDS);

    // ==================================================================
    // flag and enable next values
    always_comb
    begin
        ctrl_nxt = ctrl_r;
        pflag_nxt = pflag_r;
        timer_nxt = timer_r;
        // software write: enables stored, flags cleared by ones
        if (wr_ctrl_w)
        begin
            ctrl_nxt = (pwdata[7:0] & ~FLAG_MASK) | (ctrl_r & FLAG_MASK & ~pwdata[7:0]);
        end
        if (wr_pflag_w)
        begin
            pflag_nxt = pflag_r & ~pwdata[PERIPH_W-1:0];
        end
        // timer count, software load wins over the tick
        if (wr_tmr_w)
        begin
            timer_nxt = pwdata[7:0];
        end
        else if (timer0_tick)
        begin
            timer_nxt = timer_r + 8'h01;
        end
        // return re-arms, acceptance disarms
        if (return_from_interrupt)
        begin
            ctrl_nxt[B_GIE] = 1'b1;
        end
        if (fire_w)
        begin
            ctrl_nxt[B_GIE] = 1'b0;
        end
        // hardware sets win over any clear, independent of enables
        ctrl_nxt[B_EXTIF] = ctrl_nxt[B_EXTIF] | ext_evt_w;
        ctrl_nxt[B_T0IF] = ctrl_nxt[B_T0IF] | wrap_w;
        ctrl_nxt[B_PCIF] = ctrl_nxt[B_PCIF] | port_evt_w;
        pflag_nxt = pflag_nxt | periph_evt;
    end

    // ==================================================================
    // sequencing: pending count, sleep and wake
    wire wake_src_w = ext_req_w | tmr_req_w | pc_req_w | per_req_w;

    always_comb
    begin
        state_nxt = state_r;
        bound_cnt_nxt = bound_cnt_r;
        in_handler_nxt = in_handler_r;
        unique case (state_r)
            ST_RUN:
            begin
                bound_cnt_nxt = 2'h0;
                if (sleep_enter)
                begin
                    state_nxt = ST_SLEEP;
                end
                else if (take_w)
                begin
                    state_nxt = ST_PEND;
                end
            end
            ST_PEND:
            begin
                // count boundaries, vector on the last one
                if (!take_w)
                begin
                    state_nxt = ST_RUN;
                end
                else if (fire_w)
                begin
                    state_nxt = ST_RUN;
                    in_handler_nxt = 1'b1;
                end
                else if (instr_boundary)
                begin
                    bound_cnt_nxt = bound_cnt_r + 2'h1;
                end
            end
            ST_SLEEP:
            begin
                bound_cnt_nxt = 2'h0;
                if (wake_src_w)
                begin
                    state_nxt = ctrl_r[B_GIE] ? ST_PEND : ST_RUN;
                end
            end
        endcase
        if (return_from_interrupt)
        begin
            in_handler_nxt = 1'b0;
        end
    end

    // ==================================================================
    // bus answer: ready one cycle after setup, read data captured then
    wire [31:0] rd_mux_w =
        sel_ctrl_w ? {24'h00_0000, ctrl_r} :
        sel_pflag_w ? widen(pflag_r) :
        sel_pen_w ? widen(pen_r) :
        sel_opt_w ? {24'h00_0000, option_r} :
        sel_tmr_w ? {24'h00_0000, timer_r} :
        sel_stat_w ? {27'h000_0000, in_handler_r, state_r, irq_r} :
        32'h0000_0000;

    // bus response registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end
        else
        begin
            pready_r <= setup_w;
            pslverr_r <= setup_w & ~mapped_w;
            prdata_r <= (setup_w & ~pwrite) ? rd_mux_w : 32'h0000_0000;
        end
    end

    // ==================================================================
    // register file
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r <= RST_CTRL;
            pflag_r <= '0;
            pen_r <= '0;
            option_r <= RST_OPTION;
            timer_r <= RST_TIMER;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            pflag_r <= pflag_nxt;
            timer_r <= timer_nxt;
            if (wr_w && sel_pen_w)
            begin
                pen_r <= pwdata[PERIPH_W-1:0];
            end
            if (wr_w && sel_opt_w)
            begin
                option_r <= pwdata[7:0];
            end
        end
    end

    // ==================================================================
    // state and core strobes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r <= ST_RUN;
            bound_cnt_r <= 2'h0;
            in_handler_r <= 1'b0;
            vector_load_r <= 1'b0;
            ret_push_r <= 1'b0;
            wake_r <= 1'b0;
            irq_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            bound_cnt_r <= bound_cnt_nxt;
            in_handler_r <= in_handler_nxt;
            vector_load_r <= fire_w;
            ret_push_r <= fire_w;
            wake_r <= (state_r == ST_SLEEP) & wake_src_w;
            irq_r <= take_w;
        end
    end

    // ==================================================================
    // outputs straight from flip-flops, vector address a constant
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign vector_load = vector_load_r;
    assign vector_addr = VECTOR_ADDR;
    assign ret_push = ret_push_r;
    assign wake = wake_r;
    assign irq = irq_r;

endmodule : irqc_ctrl

//--- irqc_ctrl_properties.sv
// Purpose: port-level checks on the interrupt controller
// Assumes: one pclk domain, bound into irqc_ctrl
// Notes: apb answer timing and vector entry relations
`timescale 1ns/1ns
module irqc_ctrl_properties
(
    // clock, reset and apb answer
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // core handshake
    input wire logic instr_boundary,
    input wire logic vector_load,
    input wire logic [12:0] vector_addr,
    input wire logic ret_push,
    input wire logic wake,
    input wire logic irq
);
    // ==================================================================
    // common clock and reset
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ==================================================================
    // apb answer
    a_ready_after_setup:
    assert property (psel && !penable |=> pready) else $error("no pready after setup");
    a_ready_one_cycle:
    assert property (pready |=> !pready) else $error("pready held too long");
    a_idle_rdata_zero:
    assert property (!pready |-> prdata == 32'h0000_0000) else $error("read data outside access");
    a_error_no_data:
    assert property (pslverr |-> pready && prdata == 32'h0000_0000) else $error("bad error answer");
    // ==================================================================
    // vector entry
    a_vector_fixed_addr:
    assert property (vector_addr == 13'h0004) else $error("vector address wrong");
    a_push_with_vector:
    assert property (vector_load == ret_push) else $error("push apart from vector load");
    a_vector_at_boundary:
    assert property (vector_load |-> $past(instr_boundary) && !$past(vector_load))
        else $error("vector off an instruction boundary");
    a_vector_needs_irq:
    assert property (vector_load |-> $past(irq)) else $error("vector without enabled request");
    a_entry_drops_irq:
    assert property (vector_load |=> !irq) else $error("global enable kept on entry");
    a_wake_single_pulse:
    assert property (wake |=> !wake) else $error("wake pulse too long");
endmodule : irqc_ctrl_properties

bind irqc_ctrl irqc_ctrl_properties irqc_ctrl_properties_i (.pclk, .presetn, .psel, .penable,
    .prdata, .pready, .pslverr, .instr_boundary, .vector_load, .vector_addr, .ret_push,
    .wake, .irq);

//--- irqc_core_model.sv
// Purpose: core-side model that ends instructions and follows vectors
// Assumes: every instruction lasts SPAN clocks
// Notes: counts entries so the bench can tell a vector from a plain wake
`timescale 1ns/1ns
module irqc_core_model
#(
    parameter int unsigned SPAN = 4 // clocks per instruction
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // controller handshake
    input wire logic vector_load,
    output logic instr_boundary,
    output logic [7:0] entry_cnt_r
);
    // instruction phase
    logic [3:0] phase_r;
    logic [3:0] phase_nxt;
    // wrap at the end of each instruction
    assign phase_nxt = (phase_r == 4'(SPAN - 1)) ? 4'h0 : phase_r + 4'h1;
    // boundary on the last clock of an instruction
    assign instr_boundary = (phase_r == 4'(SPAN - 1));
    // phase and entry counting
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase_r <= 4'h0;
            entry_cnt_r <= 8'h00;
        end
        else
        begin
            phase_r <= phase_nxt;
            entry_cnt_r <= entry_cnt_r + 8'(vector_load);
        end
    end
endmodule : irqc_core_model

//--- testbench.sv
// Purpose: directed bench for the interrupt flag and vector controller
// Assumes: core model ends an instruction every 4 clocks
// Notes: registers reached over apb only; one line per finished test
`timescale 1ns/1ns
module testbench;
    import irqc_pkg::*;
    // ==================================================================
    // stimulus and observed signals
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd_q;
    logic pready, pslverr, err_q;
    logic ext_irq_pin = 1'b0, timer0_tick = 1'b0;
    logic [3:0] port_b_pins = 4'h0;
    logic [7:0] periph_evt = 8'h00;
    logic return_from_interrupt = 1'b0, sleep_enter = 1'b0;
    logic instr_boundary, vector_load, ret_push, wake, irq, ctx_hit;
    logic [12:0] vector_addr;
    logic [1:0] ctx_bank = 2'h0;
    logic [6:0] ctx_addr = 7'h00;
    logic ctx_wr = 1'b0;
    logic [7:0] ctx_wdata = 8'h00, ctx_rdata, entry_cnt_r;
    int err_total = 0, total_checks = 0;
    // ==================================================================
    // design, core model and clock
    irqc_ctrl irqc_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .ext_irq_pin, .port_b_pins, .timer0_tick, .periph_evt,
        .instr_boundary, .return_from_interrupt, .sleep_enter, .vector_load, .vector_addr,
        .ret_push, .wake, .irq, .ctx_bank, .ctx_addr, .ctx_wr, .ctx_wdata, .ctx_rdata,
        .ctx_hit);
    irqc_core_model irqc_core_model_i (.pclk, .presetn, .vector_load, .instr_boundary,
        .entry_cnt_r);
    initial forever #10 pclk = ~pclk;
    // ==================================================================
    // report, compare and bus tasks
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic hang(input string what);
        err_total++;
        $display("ERROR %s expected answer seen timeout", what);
        end_of_test();
    endtask : hang
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (n >= 16) hang("pready");
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0000_0000);
        chk(what, exp, rd_q);
    endtask : rd_chk
    // wait for vector or wake, counting instruction boundaries
    task automatic wait_hi(input bit use_wake, output int nb);
        int n = 0;
        nb = 0;
        while ((use_wake ? wake : vector_load) !== 1'b1)
        begin
            @(posedge pclk);
            n++;
            nb += int'(instr_boundary === 1'b1);
            if (n > 300) hang("vector or wake");
        end
    endtask : wait_hi
    // ==================================================================
    // main sequence
    initial
    begin
        int nb;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        tick(2);
        rd_chk(OFF_CTRL, 32'h0000_0000, "ctrl reset");
        rd_chk(OFF_OPTION, 32'h0000_00FF, "option reset");
        rd_chk(8'h18, 32'h0000_0000, "unmapped data");
        chk("unmapped error", 32'h0000_0001, 32'(err_q));
        $display("test reset done");
        ext_irq_pin <= 1'b1;
        tick(3);
        rd_chk(OFF_CTRL, 32'h0000_0002, "rising flag");
        wr(OFF_CTRL, 32'h0000_0002);
        wr(OFF_OPTION, 32'h0000_00BF);
        ext_irq_pin <= 1'b0;
        tick(3);
        rd_chk(OFF_CTRL, 32'h0000_0002, "falling flag");
        wr(OFF_CTRL, 32'h0000_0002);
        ext_irq_pin <= 1'b1;
        tick(3);
        rd_chk(OFF_CTRL, 32'h0000_0000, "rising ignored");
        wr(OFF_TIMER, 32'h0000_00FF);
        timer0_tick <= 1'b1;
        port_b_pins <= 4'h8;
        periph_evt <= 8'h01;
        tick(1);
        timer0_tick <= 1'b0;
        periph_evt <= 8'h00;
        tick(2);
        rd_chk(OFF_CTRL, 32'h0000_0005, "wrap and change");
        rd_chk(OFF_TIMER, 32'h0000_0000, "timer wrapped");
        rd_chk(OFF_PFLAG, 32'h0000_0001, "periph flag");
        wr(OFF_CTRL, 32'h0000_0005);
        wr(OFF_PFLAG, 32'h0000_0001);
        rd_chk(OFF_CTRL, 32'h0000_0000, "flags cleared");
        $display("test events done");
        wr(OFF_CTRL, 32'h0000_0090);
        ext_irq_pin <= 1'b0;
        wait_hi(1'b0, nb);
        chk("latency", 32'h0000_0001, 32'(nb inside {3, 4}));
        chk("vector address", 32'(VECTOR_ADDR), 32'(vector_addr));
        chk("return push", 32'h0000_0001, 32'(ret_push));
        chk("irq at entry", 32'h0000_0001, 32'(irq));
        tick(1);
        chk("entries", 32'h0000_0001, 32'(entry_cnt_r));
        chk("irq after entry", 32'h0000_0000, 32'(irq));
        rd_chk(OFF_CTRL, 32'h0000_0012, "entry state");
        wr(OFF_CTRL, 32'h0000_0012);
        return_from_interrupt <= 1'b1;
        tick(1);
        return_from_interrupt <= 1'b0;
        tick(1);
        rd_chk(OFF_CTRL, 32'h0000_0090, "reenabled");
        $display("test vector done");
        wr(OFF_PEN, 32'h0000_0001);
        wr(OFF_CTRL, 32'h0000_0040);
        periph_evt <= 8'h01;
        tick(1);
        periph_evt <= 8'h00;
        tick(20);
        chk("global blocks", 32'h0000_0001, 32'(entry_cnt_r));
        wr(OFF_CTRL, 32'h0000_0080);
        tick(20);
        chk("group gated", 32'h0000_0001, 32'(entry_cnt_r));
        wr(OFF_CTRL, 32'h0000_00C0);
        wait_hi(1'b0, nb);
        tick(1);
        chk("group open", 32'h0000_0002, 32'(entry_cnt_r));
        wr(OFF_PFLAG, 32'h0000_0001);
        return_from_interrupt <= 1'b1;
        tick(1);
        return_from_interrupt <= 1'b0;
        $display("test periph done");
        ext_irq_pin <= 1'b1;
        wr(OFF_CTRL, 32'h0000_0010);
        sleep_enter <= 1'b1;
        tick(1);
        sleep_enter <= 1'b0;
        ext_irq_pin <= 1'b0;
        wait_hi(1'b1, nb);
        tick(8);
        chk("no branch", 32'h0000_0002, 32'(entry_cnt_r));
        rd_chk(OFF_CTRL, 32'h0000_0012, "wake cause");
        rd_chk(OFF_STATUS, 32'h0000_0002, "status after wake");
        $display("test sleep done");
        ctx_addr <= 7'h75;
        ctx_wdata <= 8'hA5;
        ctx_wr <= 1'b1;
        tick(1);
        ctx_wr <= 1'b0;
        ctx_bank <= 2'h3;
        tick(2);
        chk("shared byte", 32'h0000_00A5, 32'(ctx_rdata));
        chk("shared hit", 32'h0000_0001, 32'(ctx_hit));
        wr(OFF_CTRL, 32'h0000_0080);
        presetn <= 1'b0;
        tick(2);
        presetn <= 1'b1;
        tick(2);
        rd_chk(OFF_CTRL, 32'h0000_0000, "second reset");
        $display("test store and reset done");
        end_of_test();
    end
endmodule : testbench
